// [hbch_config_bank.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - Revision number is read-only and returns the fixed revision.
// - Sub-class code reads 00h, host bridge, and ignores writes.
// - Base class code reads 06h, bridge, and ignores writes.
// - Header type reads 80h with extra functions on, 00h when all off.
// - Header type has no storage; derived from function enables, writes ignored.
// - Board vendor identifier resets to zero, takes one write, then locks.
// - Board product identifier resets to zero, takes one write, then locks.
// - Capability pointer is read-only and returns 40h.
// - The 40-bit feature ceiling register is read-only; writes ignored.
// - Ceiling bits 27:24 read 0001b, structure revision one.
// - Ceiling bits 23:16 read 05h, the structure length.
// - Ceiling bit 29 disables device 1, zeroes next pointer, locks aperture.
// - Ceiling limits device 1 and the aperture; selections above the ceiling are stored but refused at the outputs.
module hbch_config_bank #(
    parameter logic [7:0] REVISION = 8'h3c, // Arbitrary revision value.
    parameter logic [2:0] PART_CODE_HI = 3'h2, // Arbitrary part code.
    parameter logic [2:0] PART_CODE_LO = 3'h2, // Arbitrary part code.
    parameter logic [7:0] ENABLED_NEXT_PTR = 8'h00,
    parameter int FUNC_COUNT = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic device1_disable_strap,
    output logic [FUNC_COUNT-2:0] function_enable,
    output logic device1_enable,
    output logic aperture_base_read_only,
    output logic aperture_global_access_enable,
    output logic [7:0] next_capability_pointer
);

    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    if (FUNC_COUNT < 2 || FUNC_COUNT > 8) begin : g_bad_count
        $error("FUNC_COUNT must lie between 2 and 8.");
    end

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_index;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ar_index;
        logic [2:0] strap_sync;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic dev1_off;
        logic [FUNC_COUNT-2:0] func_en;
        logic dev1_req;
        logic aperture_req;
        logic dev1_en;
        logic aperture_en;
        logic [7:0] next_ptr;
    } hbch_state_t;

    hbch_state_t state_reg;
    hbch_state_t state_next;
    logic vendor_we;
    logic product_we;
    logic [15:0] vendor_value;
    logic [15:0] product_value;
    logic [39:0] ceiling;

    // Word index of a byte address; the two low bits are ignored.
    function automatic logic [7:0] addr_index(input logic [11:0] addr);
        addr_index = addr[9:2];
    endfunction : addr_index

    // Whether an address falls outside the upper index range.
    function automatic logic addr_high(input logic [11:0] addr);
        addr_high = |addr[11:10];
    endfunction : addr_high

    // Byte lane mask for a 16-bit register in the low half of a word.
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Ceiling value with fixed fields and zero reserved bits.
    always_comb begin
        ceiling = '0;
        ceiling[hbch_pkg::CEIL_PART_HI_POS+:3] = PART_CODE_HI;
        ceiling[hbch_pkg::CEIL_DEV1_OFF_POS] = state_reg.dev1_off;
        ceiling[hbch_pkg::CEIL_VERSION_POS+:4] = hbch_pkg::CEIL_VERSION_VALUE;
        ceiling[hbch_pkg::CEIL_LENGTH_POS+:8] = hbch_pkg::CEIL_LENGTH_VALUE;
        ceiling[hbch_pkg::CEIL_PART_LO_POS+:3] = PART_CODE_LO;
    end

    // Read word for a register index; unmapped indexes flag an error.
    function automatic logic [32:0] read_word(input logic [7:0] idx, input logic high,
        input hbch_state_t st, input logic [39:0] ceil,
        input logic [15:0] vend, input logic [15:0] prod);
        logic [31:0] w;
        logic err;
        w = '0;
        err = 1'b0;
        if (high) begin
            err = 1'b1;
        end else if (idx == hbch_pkg::IDX_REVISION) begin
            w[7:0] = REVISION;
        end else if (idx == hbch_pkg::IDX_SUBCLASS) begin
            w[7:0] = hbch_pkg::SUBCLASS_HOST_BRIDGE;
        end else if (idx == hbch_pkg::IDX_BASE_CLASS) begin
            w[7:0] = hbch_pkg::BASE_CLASS_BRIDGE;
        end else if (idx == hbch_pkg::IDX_HEADER_TYPE) begin
            w[7:0] = (|st.func_en) ? hbch_pkg::HEADER_MULTI_FUNCTION
                : hbch_pkg::HEADER_SINGLE_FUNCTION;
        end else if (idx == hbch_pkg::IDX_BOARD_VENDOR) begin
            w[15:0] = vend;
        end else if (idx == hbch_pkg::IDX_BOARD_PRODUCT) begin
            w[15:0] = prod;
        end else if (idx == hbch_pkg::IDX_CAP_POINTER) begin
            w[7:0] = hbch_pkg::CAP_POINTER_VALUE;
        end else if (idx == hbch_pkg::IDX_CEILING_LOW) begin
            w = ceil[31:0];
        end else if (idx == hbch_pkg::IDX_CEILING_HIGH) begin
            w[7:0] = ceil[39:32];
        end else if (idx == hbch_pkg::IDX_FEATURE_SELECT) begin
            w[FUNC_COUNT-2:0] = st.func_en;
            w[hbch_pkg::SEL_DEV1_POS] = st.dev1_req;
            w[hbch_pkg::SEL_APERTURE_POS] = st.aperture_req;
            w[hbch_pkg::SEL_DEV1_EFF_POS] = st.dev1_en;
            w[hbch_pkg::SEL_APERTURE_EFF_POS] = st.aperture_en;
            w[hbch_pkg::SEL_STRAP_DONE_POS] = st.strap_done;
        end else begin
            err = 1'b1;
        end
        read_word = {err, w};
    endfunction : read_word

    // ****************************************************************
    // Next-state logic: bus slave, strap capture and feature limits.
    // ****************************************************************
    always_comb begin
        logic [32:0] rd;
        logic wr_fire;
        logic wr_err;
        rd = '0;
        wr_fire = 1'b0;
        wr_err = 1'b0;
        state_next = state_reg;
        vendor_we = 1'b0;
        product_we = 1'b0;
        // Address and data are taken independently, in either order.
        if (state_reg.awready && s_axi_awvalid) begin
            state_next.aw_got = 1'b1;
            state_next.aw_index = addr_high(s_axi_awaddr) ? 8'hff : addr_index(s_axi_awaddr);
        end
        if (state_reg.wready && s_axi_wvalid) begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        // Once both halves are held the write acts and its response is raised.
        wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
        if (wr_fire) begin
            rd = read_word(state_reg.aw_index, 1'b0, state_reg, ceiling,
                vendor_value, product_value);
            wr_err = rd[32];
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = wr_err ? hbch_pkg::RESP_SLVERR : hbch_pkg::RESP_OKAY;
            if (state_reg.aw_index == hbch_pkg::IDX_BOARD_VENDOR) begin
                vendor_we = |state_reg.w_strb[1:0];
            end else if (state_reg.aw_index == hbch_pkg::IDX_BOARD_PRODUCT) begin
                product_we = |state_reg.w_strb[1:0];
            end else if (state_reg.aw_index == hbch_pkg::IDX_FEATURE_SELECT) begin
                if (state_reg.w_strb[0]) begin
                    state_next.func_en = state_reg.w_data[FUNC_COUNT-2:0];
                end
                if (state_reg.w_strb[1]) begin
                    state_next.dev1_req = state_reg.w_data[hbch_pkg::SEL_DEV1_POS];
                    state_next.aperture_req = state_reg.w_data[hbch_pkg::SEL_APERTURE_POS];
                end
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        state_next.awready = !state_next.aw_got && !state_next.bvalid;
        state_next.wready = !state_next.w_got && !state_next.bvalid;
        // A read is answered on the same edge that takes its address.
        if (state_reg.arready && s_axi_arvalid) begin
            rd = read_word(addr_index(s_axi_araddr), addr_high(s_axi_araddr), state_reg,
                ceiling, vendor_value, product_value);
            state_next.rvalid = 1'b1;
            state_next.rdata = rd[31:0];
            state_next.rresp = rd[32] ? hbch_pkg::RESP_SLVERR : hbch_pkg::RESP_OKAY;
            state_next.ar_index = addr_high(s_axi_araddr) ? 8'hff : addr_index(s_axi_araddr);
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        state_next.arready = !state_next.rvalid;
        // The strap is caught once, after it has settled through the synchroniser.
        state_next.strap_sync = {state_reg.strap_sync[1:0], device1_disable_strap};
        if (!state_reg.strap_done) begin
            if (state_reg.strap_cnt != hbch_pkg::STRAP_SETTLE_COUNT) begin
                state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
            end else if (state_reg.strap_sync[1] == state_reg.strap_sync[2]) begin
                state_next.strap_done = 1'b1;
                state_next.dev1_off = state_reg.strap_sync[2];
            end
        end
        // Selections above the ceiling are refused at the outputs.
        state_next.dev1_en = state_next.strap_done && state_next.dev1_req
            && !state_next.dev1_off;
        state_next.aperture_en = state_next.strap_done && state_next.aperture_req
            && !state_next.dev1_off;
        state_next.next_ptr = state_next.dev1_off ? hbch_pkg::NEXT_POINTER_NONE
            : ENABLED_NEXT_PTR;
    end

    // State register with synchronous active-low reset.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.func_en <= '1;
            state_reg.dev1_req <= hbch_pkg::SEL_DEV1_RESET;
            state_reg.aperture_req <= hbch_pkg::SEL_APERTURE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Write-once board identifiers.
    // ****************************************************************
    hbch_write_once #(.WIDTH(16)) u_vendor (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .write_en(vendor_we),
        .write_data(state_reg.w_data[15:0]),
        .write_mask(lane_mask(state_reg.w_strb)),
        .value(vendor_value),
        .locked()
    );

    hbch_write_once #(.WIDTH(16)) u_product (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .write_en(product_we),
        .write_data(state_reg.w_data[15:0]),
        .write_mask(lane_mask(state_reg.w_strb)),
        .value(product_value),
        .locked()
    );

    // Outputs come straight from the state register.
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign function_enable = state_reg.func_en;
    assign device1_enable = state_reg.dev1_en;
    assign aperture_base_read_only = state_reg.dev1_off;
    assign aperture_global_access_enable = state_reg.aperture_en;
    assign next_capability_pointer = state_reg.next_ptr;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    revision_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_REVISION)
        |-> state_reg.rdata == {24'h000000, REVISION})
        else $error("Revision read wrong.");
    subclass_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_SUBCLASS)
        |-> state_reg.rdata == 32'h00000000)
        else $error("Sub-class read wrong.");
    base_class_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_BASE_CLASS)
        |-> state_reg.rdata == 32'h00000006)
        else $error("Base class read wrong.");
    header_type_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_HEADER_TYPE)
        |-> state_reg.rdata == ($past(|state_reg.func_en) ? 32'h00000080 : 32'h00000000))
        else $error("Header type does not follow function enables.");
    cap_pointer_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_CAP_POINTER)
        |-> state_reg.rdata == 32'h00000040)
        else $error("Capability pointer read wrong.");
    ceiling_fields_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_CEILING_LOW)
        |-> (state_reg.rdata[27:16] == 12'h105 && state_reg.rdata[15:8] == 8'h00
            && state_reg.rdata[4:0] == 5'h00 && state_reg.rdata[28] == 1'b0))
        else $error("Ceiling fields wrong.");
    ceiling_high_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(state_reg.rvalid) && state_reg.ar_index == hbch_pkg::IDX_CEILING_HIGH)
        |-> (state_reg.rdata[31:8] == 24'h000000 && state_reg.rdata[4:0] == 5'h00))
        else $error("Ceiling reserved bits not zero.");
    device1_off_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        state_reg.dev1_off |-> (!device1_enable && !aperture_global_access_enable
            && next_capability_pointer == 8'h00 && aperture_base_read_only))
        else $error("Device 1 not shut off by ceiling.");
    ceiling_limit_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_reg.dev1_req && state_reg.strap_done && !state_reg.dev1_off)
        |=> (device1_enable || $changed(state_reg.dev1_req)))
        else $error("Device 1 selection not served under ceiling.");
endmodule : hbch_config_bank

// [hbch_config_bank_tb.sv]
`timescale 1ns/1ps
module hbch_config_bank_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic strap = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dev1_en, ap_ro, ap_en;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    logic [2:0] fen;
    logic [7:0] nxt;
    logic [34:0] e;
    logic [34:0] rq[$];
    logic [1:0] bq[$];
    logic [11:0] ro_a[7] = '{12'h020, 12'h028, 12'h02c, 12'h038, 12'h0d0, 12'h100, 12'h104};
    logic [31:0] ro_d[7] = '{32'h3c, 32'h0, 32'h6, 32'h80, 32'h40, 32'h0105_0040, 32'h40};
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    // Free-running clock, 10 ns period.
    always #5 ref_clk = ~ref_clk;

    // A non-zero enabled pointer lets the shut-off check see the pointer change.
    hbch_config_bank #(.ENABLED_NEXT_PTR(8'h50)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .device1_disable_strap(strap), .function_enable(fen),
        .device1_enable(dev1_en), .aperture_base_read_only(ap_ro),
        .aperture_global_access_enable(ap_en), .next_capability_pointer(nxt));

    // ****************************************************************
    // Checking and reporting.
    // ****************************************************************
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Takes the oldest expectation off a queue whenever an answer is handed over.
    always @(posedge ref_clk) begin
        if (bvalid && bready && bq.size() > 0) chk("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready && rq.size() > 0) begin
            e = rq.pop_front();
            chk("read", {rresp, rdata & {32{e[34]}}}, e[33:0]);
        end
    end

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ****************************************************************
    // Bus master tasks; each holds every signal until its own handshake.
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge ref_clk);
        while (awvalid || wvalid || bready) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : wr

    // The flag c says whether the read data is compared.
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                      input logic c);
        rq.push_back({c, r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge ref_clk);
        while (arvalid || rready) begin
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : rd

    task automatic do_reset(input logic s);
        rstn <= 1'b0;
        strap <= s;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (10) @(posedge ref_clk);
    endtask : do_reset

    // Main sequence: fixed codes, write protection, write-once ids, header, errors, strap.
    initial begin
        void'($urandom(31753));
        do_reset(1'b0);
        for (int i = 0; i < 7; i++) rd(ro_a[i], ro_d[i], hbch_pkg::RESP_OKAY, 1'b1);
        rd(12'h180, 32'h0007_0307, hbch_pkg::RESP_OKAY, 1'b1);
        chk("ports", {20'h0, fen, dev1_en, ap_ro, ap_en, nxt}, {20'h0, 3'h7, 3'h5, 8'h50});
        $display("test reset values done");
        for (int i = 0; i < 7; i++) wr(ro_a[i], $urandom, 4'hf, hbch_pkg::RESP_OKAY);
        for (int i = 0; i < 7; i++) rd(ro_a[i], ro_d[i], hbch_pkg::RESP_OKAY, 1'b1);
        $display("test read-only writes done");
        for (int i = 0; i < 2; i++) begin
            v = $urandom;
            rd(12'h0b0 + 12'(8 * i), 32'h0, hbch_pkg::RESP_OKAY, 1'b1);
            wr(12'h0b0 + 12'(8 * i), v, 4'hf, hbch_pkg::RESP_OKAY);
            wr(12'h0b0 + 12'(8 * i), ~v, 4'hf, hbch_pkg::RESP_OKAY);
            rd(12'h0b0 + 12'(8 * i), {16'h0, v[15:0]}, hbch_pkg::RESP_OKAY, 1'b1);
        end
        $display("test write-once ids done");
        wr(12'h180, 32'h0, 4'h1, hbch_pkg::RESP_OKAY);
        rd(12'h038, 32'h0, hbch_pkg::RESP_OKAY, 1'b1);
        chk("function_enable", 34'(fen), 34'h0);
        wr(12'h180, 32'h7, 4'h1, hbch_pkg::RESP_OKAY);
        rd(12'h038, 32'h80, hbch_pkg::RESP_OKAY, 1'b1);
        $display("test header type done");
        wr(12'h1fc, $urandom, 4'hf, hbch_pkg::RESP_SLVERR);
        rd(12'h1fc, 32'h0, hbch_pkg::RESP_SLVERR, 1'b0);
        rd(12'hc20, 32'h0, hbch_pkg::RESP_SLVERR, 1'b0);
        $display("test unmapped done");
        do_reset(1'b1);
        rd(12'h0b0, 32'h0, hbch_pkg::RESP_OKAY, 1'b1);
        rd(12'h100, 32'h2105_0040, hbch_pkg::RESP_OKAY, 1'b1);
        wr(12'h180, 32'h0000_0307, 4'h3, hbch_pkg::RESP_OKAY);
        rd(12'h180, 32'h0004_0307, hbch_pkg::RESP_OKAY, 1'b1);
        chk("ports", {20'h0, fen, dev1_en, ap_ro, ap_en, nxt}, {20'h0, 3'h7, 3'h2, 8'h00});
        $display("test ceiling strap done");
        final_report();
    end
endmodule : hbch_config_bank_tb

// [hbch_pkg.sv]
package hbch_pkg;

    // ****************************************************************
    // Register indexes; the byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] IDX_REVISION = 8'h08;
    localparam logic [7:0] IDX_SUBCLASS = 8'h0a;
    localparam logic [7:0] IDX_BASE_CLASS = 8'h0b;
    localparam logic [7:0] IDX_HEADER_TYPE = 8'h0e;
    localparam logic [7:0] IDX_BOARD_VENDOR = 8'h2c;
    localparam logic [7:0] IDX_BOARD_PRODUCT = 8'h2e;
    localparam logic [7:0] IDX_CAP_POINTER = 8'h34;
    localparam logic [7:0] IDX_CEILING_LOW = 8'h40;
    localparam logic [7:0] IDX_CEILING_HIGH = 8'h41;
    localparam logic [7:0] IDX_FEATURE_SELECT = 8'h60;

    // ****************************************************************
    // Fixed register values.
    // ****************************************************************
    localparam logic [7:0] SUBCLASS_HOST_BRIDGE = 8'h00;
    localparam logic [7:0] BASE_CLASS_BRIDGE = 8'h06;
    localparam logic [7:0] HEADER_MULTI_FUNCTION = 8'h80;
    localparam logic [7:0] HEADER_SINGLE_FUNCTION = 8'h00;
    localparam logic [7:0] CAP_POINTER_VALUE = 8'h40;
    localparam logic [7:0] NEXT_POINTER_NONE = 8'h00;
    localparam logic [15:0] BOARD_ID_RESET = 16'h0000;

    // ****************************************************************
    // Feature ceiling register fields.
    // ****************************************************************
    localparam int CEIL_PART_HI_POS = 37;
    localparam int CEIL_DEV1_OFF_POS = 29;
    localparam int CEIL_VERSION_POS = 24;
    localparam int CEIL_LENGTH_POS = 16;
    localparam int CEIL_PART_LO_POS = 5;
    localparam logic [3:0] CEIL_VERSION_VALUE = 4'h1;
    localparam logic [7:0] CEIL_LENGTH_VALUE = 8'h05;

    // ****************************************************************
    // Feature select register fields and reset values.
    // ****************************************************************
    localparam int SEL_DEV1_POS = 8;
    localparam int SEL_APERTURE_POS = 9;
    localparam int SEL_DEV1_EFF_POS = 16;
    localparam int SEL_APERTURE_EFF_POS = 17;
    localparam int SEL_STRAP_DONE_POS = 18;
    localparam logic SEL_DEV1_RESET = 1'b1;
    localparam logic SEL_APERTURE_RESET = 1'b1;

    // ****************************************************************
    // Bus answers and strap settling.
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] STRAP_SETTLE_COUNT = 2'h3;

endpackage : hbch_pkg

// [hbch_write_once.sv]
`timescale 1ns/1ps

// A register that takes its first write and then keeps its value.
module hbch_write_once #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic write_en,
    input wire logic [WIDTH-1:0] write_data,
    input wire logic [WIDTH-1:0] write_mask,
    output logic [WIDTH-1:0] value,
    output logic locked
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
        logic locked;
    } hbch_wo_state_t;

    hbch_wo_state_t state_reg;
    hbch_wo_state_t state_next;

    // The first write stores the enabled bits and locks; later ones are dropped.
    always_comb begin
        state_next = state_reg;
        if (write_en && !state_reg.locked) begin
            state_next.value = (state_reg.value & ~write_mask) | (write_data & write_mask);
            state_next.locked = 1'b1;
        end
    end

    // State register with synchronous reset to zero and unlocked.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg.value <= WIDTH'(hbch_pkg::BOARD_ID_RESET);
            state_reg.locked <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;
    assign locked = state_reg.locked;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    locked_value_hold_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        state_reg.locked |=> (state_reg.locked && $stable(state_reg.value)))
        else $error("Write-once value changed after lock.");

    first_write_lock_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (write_en && !state_reg.locked) |=> (state_reg.locked
            && ((state_reg.value & $past(write_mask)) == ($past(write_data) & $past(write_mask)))))
        else $error("First write not stored or not locked.");

endmodule : hbch_write_once
